// File: ssw_glitch_filter.sv
// Purpose: synchronise a pin and reject pulses shorter than a set count
// Assumes: input is asynchronous to clk
// Notes: output changes only after the input has stood stable long enough
`timescale 1ns/1ps
module ssw_glitch_filter #(
  parameter int unsigned STABLE = 10,
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic meta_q;
  logic sync_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic level_d;
  wire differ = (sync_q != level_o);
  wire settled = (cnt_q == 4'(STABLE - 1));

  // count stable cycles while the synced level differs from the output
  assign cnt_d = (!differ || settled) ? ssw_pkg::FILT_RST : cnt_q + 4'h1;
  assign level_d = (differ && settled) ? sync_q : level_o;

  // two-flop synchroniser then filter register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      cnt_q <= ssw_pkg::FILT_RST;
      level_o <= RST_VAL;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      cnt_q <= cnt_d;
      level_o <= level_d;
    end
  end
endmodule : ssw_glitch_filter

// File: ssw_mcu_model.sv
// Purpose: controller model on the reset pins and the serial bus
// Assumes: pull-up on the low pin and sda, pull-down on the high pin
// Notes: sda toggles every 64 cycles while sda_run is high
`timescale 1ns/1ps
module ssw_mcu_model (
  // clock
  input wire logic clk,
  // device side of the reset pins
  input wire logic lo_o,
  input wire logic lo_oe_b,
  input wire logic hi_o,
  input wire logic hi_oe_b,
  // bench controls
  input wire logic press_lo,
  input wire logic press_hi,
  input wire logic sda_run,
  input wire logic sda_glitch,
  // resolved pin levels
  output logic lo_i,
  output logic hi_i,
  output logic sda_i,
  output logic scl_i
);
  logic [5:0] div_q = 6'h00;
  logic sda_q = 1'b1;
  // either party may assert a reset pin, resistors give the idle level
  assign lo_i = !((!lo_oe_b && !lo_o) || press_lo);
  assign hi_i = (!hi_oe_b && hi_o) || press_hi;
  assign sda_i = sda_q ^ sda_glitch;
  assign scl_i = div_q[5];
  // bus activity that keeps the watchdog cleared, moved on the rising edge so
  // the block samples the old level and bench controls set on the falling edge
  always @(posedge clk) begin
    div_q <= div_q + 6'h01;
    if (sda_run && div_q == 6'h3F) sda_q <= !sda_q;
  end
endmodule : ssw_mcu_model

// File: ssw_pkg.sv
// Purpose: constants for the supply supervisor and watchdog block
// Assumes: 50 MHz clock, one clock domain, synchronous active-low reset
// Notes: long counts are top-level parameters that default to these values
//
// Contract
// - both reset outputs stay asserted while the supply is below threshold and for the power-up timeout after it rises.
// - after the timeout both reset pins are released to their external resistors.
// - a below-threshold indication asserts both reset outputs at once.
// - an external agent forcing either reset pin active starts and holds a reset on both outputs; the code releases both for 3 cycles at each timeout if held.
// - a rising edge on the active-high reset pin starts a reset timeout.
// - a falling edge on the active-low reset pin starts a reset timeout.
// - with no serial data transition for 1.6 s the watchdog forces a reset.
// - any serial data transition clears the watchdog; the controller must toggle it often enough.
// - while reset is asserted the watchdog count is held at zero.
// - the watchdog is a build option; without it no watchdog reset ever occurs.
// - a high write-protect pin makes the memory read only.
// - memory writes are inhibited while the supply is below threshold.
// - while reset is active memory accesses are ignored and no acknowledge is given.
// - a stop ending a write starts an internal write cycle of at most 10 ms with the bus disabled.
// - serial clock and data pulses shorter than 200 ns are filtered out.
package ssw_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;
  // power-up reset timeout, nominal 200 ms
  localparam int unsigned PUR_TMO_MS = 200;
  localparam int unsigned PUR_TMO_CYC = PUR_TMO_MS * (CLK_HZ / 1000);
  // watchdog period 1.6 s, kept in ms
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  // internal write cycle time, longest 10 ms, rounded down
  localparam int unsigned WRCYC_MS = 10;
  localparam int unsigned WRCYC_CYC = WRCYC_MS * (CLK_HZ / 1000);
  // noise suppression 200 ns, least time rounded up
  localparam int unsigned NOISE_NS = 200;
  localparam int unsigned NOISE_CYC = (NOISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 27;
  localparam logic [3:0] FILT_RST = 4'h0;
  // supervisor states
  typedef enum logic [2:0] {
    SSW_LOW  = 3'b001,
    SSW_HOLD = 3'b010,
    SSW_RUN  = 3'b100
  } ssw_state_t;
endpackage : ssw_pkg

// File: ssw_supervisor.sv
// Purpose: reset supervisor, watchdog and memory write gating
// Assumes: supply_low is a comparator level from the analog threshold circuit
// Notes: reset pins are open drain, enable low while driving
`timescale 1ns/1ps
module ssw_supervisor #(
  parameter bit HAS_WDOG = 1'b1,
  parameter int unsigned PUR_TMO_CYCLES = ssw_pkg::PUR_TMO_CYC,
  parameter int unsigned WDOG_CYCLES = ssw_pkg::WDOG_CYC,
  parameter int unsigned WRCYC_CYCLES = ssw_pkg::WRCYC_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // supply comparator, high while below reset_threshold
  input wire logic supply_low,
  // active-low reset pin
  input wire logic rst_lo_pin_i,
  output logic rst_lo_pin_o,
  output logic rst_lo_pin_oe_b,
  // active-high reset pin
  input wire logic rst_hi_pin_i,
  output logic rst_hi_pin_o,
  output logic rst_hi_pin_oe_b,
  // serial bus pins
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  output logic scl_filt,
  output logic sda_filt,
  // write protect pin, pulled low when floating
  input wire logic wp_pin_i,
  // protocol engine handshake
  input wire logic wr_stop,
  input wire logic ack_req,
  output logic ack_allow,
  output logic write_allow,
  output logic bus_busy,
  output logic reset_active
);
  ssw_pkg::ssw_state_t state_q;
  ssw_pkg::ssw_state_t state_d;
  logic [ssw_pkg::CNT_W-1:0] tmo_q;
  logic [ssw_pkg::CNT_W-1:0] wdg_q;
  logic [ssw_pkg::CNT_W-1:0] wr_q;
  logic sup_m_q;
  logic sup_q;
  logic wp_m_q;
  logic wp_q;
  logic lo_m_q;
  logic lo_s_q;
  logic lo_prev_q;
  logic hi_m_q;
  logic hi_s_q;
  logic hi_prev_q;
  logic drive_q;
  logic sda_prev_q;
  logic ack_q;
  logic [1:0] echo_q;

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  // pin noise filters
  ssw_glitch_filter #(.STABLE(ssw_pkg::NOISE_CYC), .RST_VAL(1'b1)) u_scl (
    .clk(clk), .rst_b(rst_b), .pin_i(scl_pin_i), .level_o(scl_filt));
  ssw_glitch_filter #(.STABLE(ssw_pkg::NOISE_CYC), .RST_VAL(1'b1)) u_sda (
    .clk(clk), .rst_b(rst_b), .pin_i(sda_pin_i), .level_o(sda_filt));

  // manual reset edges, masked while we drive the pins ourselves
  // our own drive is still seen through the synchronisers two cycles after release
  wire own_drive = drive_q || echo_q[0] || echo_q[1];
  wire lo_fall = lo_prev_q && !lo_s_q && !own_drive;
  wire hi_rise = !hi_prev_q && hi_s_q && !own_drive;
  wire pin_held = (!lo_s_q || hi_s_q) && !own_drive;
  wire sda_edge = (sda_filt != sda_prev_q);
  wire wdg_fire = HAS_WDOG && (wdg_q == ssw_pkg::CNT_W'(WDOG_CYCLES - 1));
  wire trig = lo_fall || hi_rise || wdg_fire || pin_held;
  wire tmo_done = (tmo_q == ssw_pkg::CNT_W'(PUR_TMO_CYCLES - 1));
  wire wr_busy = (wr_q != '0);

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  // supervisor next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ssw_pkg::SSW_LOW:  if (!sup_q) state_d = ssw_pkg::SSW_HOLD;
      ssw_pkg::SSW_HOLD: if (sup_q) state_d = ssw_pkg::SSW_LOW;
                         else if (tmo_done && !trig) state_d = ssw_pkg::SSW_RUN;
      ssw_pkg::SSW_RUN:  if (sup_q) state_d = ssw_pkg::SSW_LOW;
                         else if (trig) state_d = ssw_pkg::SSW_HOLD;
      default: state_d = ssw_pkg::SSW_LOW;
    endcase
  end

  // ---------------------------------------------------------------
  // pin drive and gating
  // ---------------------------------------------------------------
  // open-drain drive: active-low pin pulls low, active-high pin pulls high
  assign rst_lo_pin_o = 1'b0;
  assign rst_hi_pin_o = 1'b1;
  assign rst_lo_pin_oe_b = !drive_q;
  assign rst_hi_pin_oe_b = !drive_q;
  assign reset_active = drive_q || !lo_s_q || hi_s_q;
  assign write_allow = !sup_q && !wp_q && !reset_active && !wr_busy;
  assign ack_allow = ack_q;
  assign bus_busy = wr_busy;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // input synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sup_m_q <= 1'b1;
      sup_q <= 1'b1;
      wp_m_q <= 1'b0;
      wp_q <= 1'b0;
      lo_m_q <= 1'b1;
      lo_s_q <= 1'b1;
      hi_m_q <= 1'b0;
      hi_s_q <= 1'b0;
    end else begin
      sup_m_q <= supply_low;
      sup_q <= sup_m_q;
      wp_m_q <= wp_pin_i;
      wp_q <= wp_m_q;
      lo_m_q <= rst_lo_pin_i;
      lo_s_q <= lo_m_q;
      hi_m_q <= rst_hi_pin_i;
      hi_s_q <= hi_m_q;
    end
  end

  // state, timeout and edge history
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ssw_pkg::SSW_LOW;
      tmo_q <= '0;
      drive_q <= 1'b1;
      lo_prev_q <= 1'b1;
      hi_prev_q <= 1'b0;
      sda_prev_q <= 1'b1;
      echo_q <= 2'h3;
    end else begin
      state_q <= state_d;
      tmo_q <= (state_d != ssw_pkg::SSW_HOLD || trig || state_q != ssw_pkg::SSW_HOLD)
               ? '0 : tmo_q + 1'b1;
      drive_q <= (state_d != ssw_pkg::SSW_RUN);
      lo_prev_q <= lo_s_q;
      hi_prev_q <= hi_s_q;
      sda_prev_q <= sda_filt;
      echo_q <= {echo_q[0], drive_q};
    end
  end

  // watchdog counter
  always_ff @(posedge clk) begin
    if (!rst_b) wdg_q <= '0;
    else if (!HAS_WDOG || reset_active || sda_edge || wdg_fire) wdg_q <= '0;
    else wdg_q <= wdg_q + 1'b1;
  end

  // internal write cycle and acknowledge gating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      ack_q <= 1'b0;
    end else begin
      if (wr_busy) wr_q <= (wr_q == ssw_pkg::CNT_W'(WRCYC_CYCLES - 1)) ? '0 : wr_q + 1'b1;
      else if (wr_stop && write_allow) wr_q <= ssw_pkg::CNT_W'(1);
      ack_q <= ack_req && !reset_active && !wr_busy && !sup_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  supply_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    sup_q |=> ##1 !rst_lo_pin_oe_b && !rst_hi_pin_oe_b)
    else $error("reset not driven while supply low");
  release_time_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(drive_q) |-> $past(state_q) == ssw_pkg::SSW_HOLD && $past(tmo_done))
    else $error("reset released before timeout");
  hold_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(drive_q) |-> $past(trig) || $past(sup_q))
    else $error("reset driven without cause");
  low_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
    lo_fall && !sup_q |=> drive_q)
    else $error("falling edge did not start reset");
  high_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
    hi_rise && !sup_q |=> drive_q)
    else $error("rising edge did not start reset");
  wdog_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    reset_active |=> wdg_q == '0)
    else $error("watchdog counted during reset");
  wdog_none_a: assert property (@(posedge clk) disable iff (!rst_b)
    !HAS_WDOG |-> !wdg_fire)
    else $error("watchdog fired when absent");
  wp_block_a: assert property (@(posedge clk) disable iff (!rst_b)
    wp_q || sup_q |-> !write_allow)
    else $error("write allowed while protected");
  ack_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    reset_active || wr_busy |=> !ack_allow)
    else $error("acknowledge during reset or write cycle");
  trig_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    trig |=> drive_q)
    else $error("trigger did not drive reset");
  wdog_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    wdg_fire |=> drive_q)
    else $error("watchdog timeout did not drive reset");
  own_echo_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(drive_q) |-> !(lo_fall || hi_rise || pin_held) [*2])
    else $error("own pin drive retriggered a reset");
  write_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_stop && write_allow |=> bus_busy)
    else $error("write cycle did not start");
  pins_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    rst_lo_pin_oe_b == rst_hi_pin_oe_b)
    else $error("reset pins driven apart");
  run_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ssw_pkg::SSW_RUN |-> rst_lo_pin_oe_b)
    else $error("reset driven in run state");
endmodule : ssw_supervisor

// File: ssw_supervisor_test.sv
// Purpose: self-checking bench for the supply supervisor
// Assumes: short counts, timeout 50, watchdog 200, write cycle 30
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module ssw_supervisor_test;
  localparam int P = 50;
  localparam int W = 200;
  localparam int WR = 30;
  logic clk, rst_b, supply_low, wp_pin_i, wr_stop, ack_req, v;
  logic press_lo, press_hi, sda_run, sda_glitch, lo_i, lo_o, lo_oe_b;
  logic hi_i, hi_o, hi_oe_b, scl_i, sda_i, scl_filt, sda_filt;
  logic ack_allow, write_allow, bus_busy, reset_active;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  // block under test with short counts
  ssw_supervisor #(.HAS_WDOG(1'b1), .PUR_TMO_CYCLES(P), .WDOG_CYCLES(W), .WRCYC_CYCLES(WR)) DUT (
    .clk(clk), .rst_b(rst_b), .supply_low(supply_low), .rst_lo_pin_i(lo_i),
    .rst_lo_pin_o(lo_o), .rst_lo_pin_oe_b(lo_oe_b), .rst_hi_pin_i(hi_i),
    .rst_hi_pin_o(hi_o), .rst_hi_pin_oe_b(hi_oe_b), .scl_pin_i(scl_i), .sda_pin_i(sda_i),
    .scl_filt(scl_filt), .sda_filt(sda_filt), .wp_pin_i(wp_pin_i), .wr_stop(wr_stop),
    .ack_req(ack_req), .ack_allow(ack_allow), .write_allow(write_allow),
    .bus_busy(bus_busy), .reset_active(reset_active));
  // controller on the far side
  ssw_mcu_model mcu (.clk(clk), .lo_o(lo_o), .lo_oe_b(lo_oe_b), .hi_o(hi_o),
    .hi_oe_b(hi_oe_b), .press_lo(press_lo), .press_hi(press_hi), .sda_run(sda_run),
    .sda_glitch(sda_glitch), .lo_i(lo_i), .hi_i(hi_i), .sda_i(sda_i), .scl_i(scl_i));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask : tick
  // count cycles until the low pin enable reaches lvl, bounded
  task automatic wait_oe(input logic lvl, input int max);
    n = 0;
    while (lo_oe_b !== lvl) begin
      tick(1);
      n++;
      if (n > max) begin
        err_total++;
        stop_test();
      end
    end
  endtask : wait_oe
  task automatic t_power();
    ack_req = 1'b1;
    tick(6);
    check({lo_oe_b, hi_oe_b, write_allow, ack_allow}, 4'h0);
    supply_low = 1'b0;
    wait_oe(1'b1, P + 12);
    check(n >= P && n <= P + 8, 1);
    tick(3);
    check({hi_oe_b, ack_allow, write_allow}, 3'h7);
    ack_req = 1'b0;
    $display("test power done");
  endtask : t_power
  task automatic t_manual(input logic hi);
    press_hi = hi;
    press_lo = !hi;
    wait_oe(1'b0, 8);
    check(n <= 6, 1);
    check({hi_oe_b, reset_active}, 2'h1);
    tick(3);
    press_hi = 1'b0;
    press_lo = 1'b0;
    wait_oe(1'b1, P + 10);
    check(n >= P - 8 && n <= P + 8, 1);
    tick(20);
    check({lo_oe_b, hi_oe_b}, 2'h3);
    $display("test manual done");
  endtask : t_manual
  task automatic t_brown();
    supply_low = 1'b1;
    wait_oe(1'b0, 8);
    check(n <= 5, 1);
    check(write_allow, 1'b0);
    supply_low = 1'b0;
    wait_oe(1'b1, P + 12);
    $display("test brownout done");
  endtask : t_brown
  task automatic t_wdog();
    n = 0;
    repeat (W + 100) begin
      tick(1);
      n += (lo_oe_b !== 1'b1);
    end
    check(n, 0);
    // stop the line just after a transition so the quiet time starts known
    v = sda_i;
    n = 0;
    while (sda_i === v && n < 70) begin
      tick(1);
      n++;
    end
    check(n < 70, 1);
    sda_run = 1'b0;
    wait_oe(1'b0, W + 20);
    check(n >= W && n <= W + 14, 1);
    wait_oe(1'b1, P + 10);
    wait_oe(1'b0, W + 10);
    check(n >= W - 4, 1);
    wait_oe(1'b1, P + 10);
    sda_run = 1'b1;
    $display("test watchdog done");
  endtask : t_wdog
  task automatic t_write();
    wp_pin_i = 1'b1;
    tick(4);
    wr_stop = 1'b1;
    tick(1);
    wr_stop = 1'b0;
    tick(1);
    check({write_allow, bus_busy}, 2'h0);
    wp_pin_i = 1'b0;
    tick(4);
    check(write_allow, 1'b1);
    ack_req = 1'b1;
    wr_stop = 1'b1;
    tick(1);
    wr_stop = 1'b0;
    check({bus_busy, write_allow}, 2'h2);
    tick(2);
    check(ack_allow, 1'b0);
    n = 0;
    while (bus_busy === 1'b1 && n < WR + 4) begin
      tick(1);
      n++;
    end
    check(n >= WR - 6 && n <= WR, 1);
    ack_req = 1'b0;
    $display("test write done");
  endtask : t_write
  task automatic t_glitch();
    sda_run = 1'b0;
    tick(16);
    v = sda_filt;
    sda_glitch = 1'b1;
    tick(5);
    sda_glitch = 1'b0;
    tick(20);
    check(sda_filt, v);
    sda_glitch = 1'b1;
    tick(20);
    check(sda_filt, !v);
    // a clean scl edge passes only after the filter delay
    v = scl_i;
    n = 0;
    while (scl_i === v && n < 70) begin
      tick(1);
      n++;
    end
    check(scl_filt, v);
    tick(14);
    check(scl_filt, !v);
    sda_glitch = 1'b0;
    sda_run = 1'b1;
    $display("test glitch done");
  endtask : t_glitch
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  // main sequence
  initial begin
    {rst_b, supply_low, wp_pin_i, wr_stop, ack_req} = 5'h08;
    {press_lo, press_hi, sda_run, sda_glitch} = 4'h2;
    tick(8);
    rst_b = 1'b1;
    t_power();
    t_manual(1'b1);
    t_manual(1'b0);
    t_brown();
    t_wdog();
    t_write();
    t_glitch();
    stop_test();
  end
endmodule : ssw_supervisor_test
